// ==== inc/mvf_defines.svh ====
// mvf_defines.svh: offsets, field positions, reset values and timing counts
// assumes: included by the framer core and the framer test
`ifndef MVF_DEFINES_SVH
`define MVF_DEFINES_SVH

// ----------------------------------------
// register byte offsets and slot register word indices
// ----------------------------------------
`define MVF_CTRL_OFS 8'h00
`define MVF_BAUD_OFS 8'h04
`define MVF_STAT_OFS 8'h08
`define MVF_SLOT_BASE 8'h10
`define MVF_SLOT_FMT 2'h0
`define MVF_SLOT_INT 2'h1
`define MVF_SLOT_FRC 2'h2

// ----------------------------------------
// control field positions and reset values
// ----------------------------------------
`define MVF_CTRL_MASK 32'h0000FFFF
`define MVF_CTRL_RST 32'h00000A11
`define MVF_FMT_MASK 32'h0FFF7FFF
`define MVF_TAIL_MAX 4'h9

// ----------------------------------------
// timing
// ----------------------------------------
`define MVF_CLK_HZ 250000000
`define MVF_BAUD_DEF 9600
`define MVF_BAUD_RST 16'(`MVF_CLK_HZ / `MVF_BAUD_DEF)

// ----------------------------------------
// character codes
// ----------------------------------------
`define MVF_CH_CTRLB 8'h02
`define MVF_CH_LF 8'h0A
`define MVF_CH_CR 8'h0D
`define MVF_CH_SP 8'h20
`define MVF_CH_QUOTE 8'h22
`define MVF_CH_PLUS 8'h2B
`define MVF_CH_MINUS 8'h2D
`define MVF_CH_POINT 8'h2E
`define MVF_CH_ZERO 8'h30
`define MVF_CH_COLON 8'h3A
`define MVF_CH_EQ 8'h3D
`define MVF_CH_UC_D 8'h44
`define MVF_CH_UC_R 8'h52
`define MVF_CH_UC_W 8'h57
`define MVF_CH_CASE 8'h20

`endif

// ==== inc/mvf_pkg.sv ====
// mvf_pkg.sv: types shared by the measured value framer
// assumes: mvf_defines.svh on the include path
package mvf_pkg;

  // ----------------------------------------
  // configuration word
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] rsvd;
    logic [1:0] sel_axis;
    logic [1:0] probe_mode;
    logic [1:0] naxes_m1;
    logic ef_en;
    logic [3:0] tail;
    logic lf_en;
    logic stop2;
    logic [1:0] parity;
    logic data8;
  } mvf_ctrl_t;

  // ----------------------------------------
  // per-axis record format
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic [3:0] nsec;
    logic [3:0] nfrac;
    logic [3:0] nint;
    logic rsvd_lo;
    logic dtg;
    logic circle_diameter_label;
    logic inch;
    logic [1:0] sign;
    logic [1:0] kind;
    logic [7:0] letter;
  } mvf_fmt_t;

  typedef enum logic [1:0] {
    MVF_K_LIN = 2'h0,
    MVF_K_DEG = 2'h1,
    MVF_K_DMS = 2'h2
  } mvf_kind_t;

  typedef enum logic [1:0] {
    MVF_P_EDGE = 2'h0,
    MVF_P_CLINE = 2'h1,
    MVF_P_CIRC = 2'h2
  } mvf_probe_t;

  typedef enum logic [13:0] {
    MVF_S_IDLE = 14'h0001,
    MVF_S_HEAD = 14'h0002,
    MVF_S_SIGN = 14'h0004,
    MVF_S_INT = 14'h0008,
    MVF_S_SEP1 = 14'h0010,
    MVF_S_G2 = 14'h0020,
    MVF_S_SEP2 = 14'h0040,
    MVF_S_G3 = 14'h0080,
    MVF_S_UNIT = 14'h0100,
    MVF_S_SUFX = 14'h0200,
    MVF_S_CR = 14'h0400,
    MVF_S_LF = 14'h0800,
    MVF_S_TAIL = 14'h1000,
    MVF_S_TLF = 14'h2000
  } mvf_state_t;

endpackage

// ==== core/mvf_framer.sv ====
// mvf_framer.sv: measured value output framer with serial transmitter
// assumes: Avalon-MM master on clk, async pins for switch, probe and rx
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`include "mvf_defines.svh"

module mvf_framer
  import mvf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic remote_switch_n,
  input wire logic edge_probe_n,
  input wire logic rxd,
  output logic txd
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] nib(input logic [31:0] w, input logic [3:0] idx);
    logic [31:0] s;
    s = w << {idx, 2'b00};
    return s[31:28];
  endfunction

  function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return ((old & ~m) | (nw & m)) & msk;
  endfunction

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic ack_q;
  logic [31:0] ctrl_q;
  logic [15:0] baud_q;
  logic [31:0] fmt_q [4];
  logic [31:0] int_q [4];
  logic [31:0] frc_q [4];
  logic [31:0] rdat_d;
  logic [7:0] rx_last_q;
  mvf_ctrl_t cfg;
  wire req_w = avs_read | avs_write;
  wire wr_go = avs_write & ack_q;
  wire in_slots = (avs_address >= `MVF_SLOT_BASE) && (avs_address < 8'h50);
  wire [7:0] slot_ofs = avs_address - `MVF_SLOT_BASE;
  wire [1:0] slot_idx = slot_ofs[5:4];
  wire [1:0] slot_reg = slot_ofs[3:2];

  assign cfg = mvf_ctrl_t'(ctrl_q);
  assign avs_waitrequest = req_w & ~ack_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_w & ~ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `MVF_CTRL_RST;
      baud_q <= `MVF_BAUD_RST;
    end else if (wr_go && avs_address == `MVF_CTRL_OFS) begin
      ctrl_q <= bmerge(ctrl_q, avs_writedata, avs_byteenable, `MVF_CTRL_MASK);
    end else if (wr_go && avs_address == `MVF_BAUD_OFS) begin
      baud_q <= 16'(bmerge({16'h0000, baud_q}, avs_writedata, avs_byteenable, 32'h0000FFFF));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        fmt_q[i] <= 32'h00000000;
        int_q[i] <= 32'h00000000;
        frc_q[i] <= 32'h00000000;
      end
    end else if (wr_go && in_slots) begin
      unique case (slot_reg)
        `MVF_SLOT_FMT: fmt_q[slot_idx] <= bmerge(fmt_q[slot_idx], avs_writedata, avs_byteenable,
                                                `MVF_FMT_MASK);
        `MVF_SLOT_INT: int_q[slot_idx] <= bmerge(int_q[slot_idx], avs_writedata, avs_byteenable,
                                                32'hFFFFFFFF);
        `MVF_SLOT_FRC: frc_q[slot_idx] <= bmerge(frc_q[slot_idx], avs_writedata, avs_byteenable,
                                                32'h00FFFFFF);
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  logic [2:0] sw_sy_q;
  logic [2:0] ef_sy_q;
  logic [1:0] rx_sy_q;
  wire sw_hit = sw_sy_q[1] & ~sw_sy_q[2];
  wire ef_hit = ef_sy_q[1] & ~ef_sy_q[2];

  always_ff @(posedge clk) begin
    if (rst) begin
      sw_sy_q <= 3'h0;
      ef_sy_q <= 3'h0;
      rx_sy_q <= 2'h3;
    end else begin
      sw_sy_q <= {sw_sy_q[1:0], ~remote_switch_n};
      ef_sy_q <= {ef_sy_q[1:0], ~edge_probe_n};
      rx_sy_q <= {rx_sy_q[0], rxd};
    end
  end

  // ----------------------------------------
  // serial receiver, watches for Ctrl B
  // ----------------------------------------
  logic rx_busy_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [9:0] rx_sh_q;
  logic ctrlb_q;
  wire [3:0] rx_nbits = 4'(cfg.data8 ? 8 : 7) + 4'(cfg.parity != 2'h0);
  wire rx_samp = rx_busy_q && rx_cnt_q == 16'h0000;
  wire rx_done = rx_samp && rx_bit_q == rx_nbits + 4'h1;
  wire [7:0] rx_char = cfg.data8 ? rx_sh_q[8:1] : {1'b0, rx_sh_q[7:1]};

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 10'h000;
      rx_last_q <= 8'h00;
      ctrlb_q <= 1'b0;
    end else begin
      ctrlb_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_sy_q[1]) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= {1'b0, baud_q[15:1]};
          rx_bit_q <= 4'h0;
          rx_sh_q <= 10'h000;
        end
      end else if (rx_samp) begin
        rx_cnt_q <= baud_q - 16'h0001;
        rx_bit_q <= rx_bit_q + 4'h1;
        rx_sh_q <= rx_sh_q | (10'(rx_sy_q[1]) << rx_bit_q);
        if (rx_bit_q == 4'h0 && rx_sy_q[1]) begin
          rx_busy_q <= 1'b0;
        end
        if (rx_done) begin
          rx_busy_q <= 1'b0;
          rx_last_q <= rx_char;
          ctrlb_q <= rx_char == `MVF_CH_CTRLB;
        end
      end else begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // serial transmitter
  // ----------------------------------------
  logic tx_busy_q;
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_left_q;
  logic [11:0] tx_sh_q;
  logic tx_go;
  logic [7:0] tx_ch;
  wire par_bit = (cfg.data8 ? ^tx_ch : ^tx_ch[6:0]) ^ cfg.parity[1];
  wire p_or_stop = (cfg.parity == 2'h0) | par_bit;
  wire [3:0] tx_len = 4'h1 + 4'(cfg.data8 ? 8 : 7) + 4'(cfg.parity != 2'h0)
                      + 4'(cfg.stop2 ? 2 : 1);
  wire [11:0] tx_frame = cfg.data8 ? {2'b11, p_or_stop, tx_ch, 1'b0}
                                   : {3'b111, p_or_stop, tx_ch[6:0], 1'b0};

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 16'h0000;
      tx_left_q <= 4'h0;
      tx_sh_q <= 12'hFFF;
    end else if (tx_go) begin
      tx_busy_q <= 1'b1;
      tx_sh_q <= tx_frame;
      tx_left_q <= tx_len;
      tx_cnt_q <= baud_q - 16'h0001;
    end else if (tx_busy_q && tx_cnt_q == 16'h0000) begin
      tx_sh_q <= {1'b1, tx_sh_q[11:1]};
      tx_left_q <= tx_left_q - 4'h1;
      tx_busy_q <= tx_left_q != 4'h1;
      tx_cnt_q <= baud_q - 16'h0001;
    end else if (tx_busy_q) begin
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    end
  end

  assign txd = tx_sh_q[0];

  // ----------------------------------------
  // request capture
  // ----------------------------------------
  logic disp_pend_q;
  logic probe_pend_q;
  logic job_probe_q;
  mvf_state_t st_q;
  mvf_state_t st_d;
  wire idle = st_q == MVF_S_IDLE;
  wire take_disp = idle & disp_pend_q;
  wire take_probe = idle & ~disp_pend_q & probe_pend_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      disp_pend_q <= 1'b0;
      probe_pend_q <= 1'b0;
    end else begin
      disp_pend_q <= (disp_pend_q & ~take_disp) | sw_hit | ctrlb_q;
      probe_pend_q <= (probe_pend_q & ~take_probe) | (ef_hit & cfg.ef_en);
    end
  end

  // ----------------------------------------
  // record sequencer
  // ----------------------------------------
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [1:0] rec_q;
  logic [1:0] rec_d;
  logic job_probe_d;
  logic [7:0] ch;
  logic emit;
  mvf_fmt_t fmt;
  wire [1:0] pmode = cfg.probe_mode;
  wire [1:0] slot = (job_probe_q && pmode == MVF_P_EDGE) ? cfg.sel_axis : rec_q;
  wire labelled = job_probe_q && pmode != MVF_P_EDGE;
  wire [1:0] nrec_m1 = !job_probe_q ? cfg.naxes_m1 : pmode == MVF_P_CIRC ? 2'h2
                       : pmode == MVF_P_CLINE ? 2'h1 : 2'h0;
  wire [3:0] head_len = job_probe_q ? 4'h4 : 4'h2;
  wire last_head = cnt_q == head_len - 4'h1;
  wire is_dms = !job_probe_q && fmt.kind == MVF_K_DMS;
  wire is_rot = !job_probe_q && fmt.kind != MVF_K_LIN;
  wire [3:0] tail_n = cfg.tail > `MVF_TAIL_MAX ? `MVF_TAIL_MAX : cfg.tail;
  wire more_rec = rec_q != nrec_m1;
  wire [7:0] lab_ch;
  wire [7:0] head_ch;
  wire [7:0] sign_ch;
  wire [7:0] sfx_ch;
  wire [23:0] lab_str;

  assign fmt = mvf_fmt_t'(fmt_q[slot]);
  assign lab_str = pmode == MVF_P_CLINE ? (rec_q == 2'h0 ? 24'h434C58 : 24'h445354)
                 : rec_q == 2'h0 ? 24'h434358 : rec_q == 2'h1 ? 24'h434359 : 24'h444941;
  assign lab_ch = cnt_q == 4'h0 ? lab_str[23:16] : cnt_q == 4'h1 ? lab_str[15:8] : lab_str[7:0];
  // edge head letter, two spaces, colon
  assign head_ch = last_head ? (job_probe_q ? `MVF_CH_COLON : `MVF_CH_EQ)
                 : labelled ? lab_ch : cnt_q == 4'h0 ? fmt.letter : `MVF_CH_SP;
  assign sign_ch = fmt.sign == 2'h1 ? `MVF_CH_MINUS
                 : (job_probe_q && fmt.sign == 2'h2) ? `MVF_CH_SP : `MVF_CH_PLUS;
  assign sfx_ch = is_rot ? (fmt.dtg ? `MVF_CH_UC_W | `MVF_CH_CASE : `MVF_CH_UC_W)
                : (fmt.circle_diameter_label ? `MVF_CH_UC_D : `MVF_CH_UC_R)
                  | ((!job_probe_q && fmt.dtg) ? `MVF_CH_CASE : 8'h00);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rec_d = rec_q;
    job_probe_d = job_probe_q;
    ch = `MVF_CH_SP;
    emit = 1'b0;
    unique case (st_q)
      MVF_S_IDLE: begin
        cnt_d = 4'h0;
        rec_d = 2'h0;
        // start a display or probe set
        if (take_disp | take_probe) begin
          job_probe_d = take_probe;
          st_d = MVF_S_HEAD;
        end
      end
      MVF_S_HEAD: begin
        ch = head_ch;
        emit = 1'b1;
        cnt_d = last_head ? 4'h0 : cnt_q + 4'h1;
        st_d = last_head ? MVF_S_SIGN : MVF_S_HEAD;
      end
      MVF_S_SIGN: begin
        ch = sign_ch;
        emit = 1'b1;
        st_d = MVF_S_INT;
      end
      MVF_S_INT: begin
        ch = `MVF_CH_ZERO | {4'h0, nib(int_q[slot], cnt_q)};
        emit = cnt_q < fmt.nint;
        cnt_d = emit ? cnt_q + 4'h1 : 4'h0;
        st_d = emit ? MVF_S_INT : MVF_S_SEP1;
      end
      MVF_S_SEP1: begin
        ch = is_dms ? `MVF_CH_COLON : `MVF_CH_POINT;
        emit = 1'b1;
        st_d = MVF_S_G2;
      end
      MVF_S_G2: begin
        ch = `MVF_CH_ZERO | {4'h0, nib({frc_q[slot][23:0], 8'h00}, cnt_q)};
        emit = cnt_q < fmt.nfrac;
        cnt_d = emit ? cnt_q + 4'h1 : 4'h0;
        st_d = emit ? MVF_S_G2 : is_dms ? MVF_S_SEP2 : MVF_S_UNIT;
      end
      MVF_S_SEP2: begin
        ch = `MVF_CH_COLON;
        emit = 1'b1;
        st_d = MVF_S_G3;
      end
      MVF_S_G3: begin
        ch = `MVF_CH_ZERO | {4'h0, nib({frc_q[slot][15:0], 16'h0000}, cnt_q)};
        emit = cnt_q < fmt.nsec;
        cnt_d = emit ? cnt_q + 4'h1 : 4'h0;
        st_d = emit ? MVF_S_G3 : MVF_S_UNIT;
      end
      MVF_S_UNIT: begin
        ch = (!is_rot && fmt.inch) ? `MVF_CH_QUOTE : `MVF_CH_SP;
        emit = 1'b1;
        st_d = MVF_S_SUFX;
      end
      MVF_S_SUFX: begin
        ch = sfx_ch;
        emit = 1'b1;
        st_d = MVF_S_CR;
      end
      MVF_S_CR: begin
        ch = `MVF_CH_CR;
        emit = 1'b1;
        st_d = cfg.lf_en ? MVF_S_LF : more_rec ? MVF_S_HEAD
             : tail_n != 4'h0 ? MVF_S_TAIL : MVF_S_IDLE;
        rec_d = (!cfg.lf_en && more_rec) ? rec_q + 2'h1 : rec_q;
      end
      MVF_S_LF: begin
        ch = `MVF_CH_LF;
        emit = 1'b1;
        st_d = more_rec ? MVF_S_HEAD : tail_n != 4'h0 ? MVF_S_TAIL : MVF_S_IDLE;
        rec_d = more_rec ? rec_q + 2'h1 : rec_q;
      end
      MVF_S_TAIL: begin
        ch = `MVF_CH_CR;
        emit = 1'b1;
        cnt_d = cnt_q + 4'h1;
        st_d = cfg.lf_en ? MVF_S_TLF : cnt_d == tail_n ? MVF_S_IDLE : MVF_S_TAIL;
      end
      MVF_S_TLF: begin
        ch = `MVF_CH_LF;
        emit = 1'b1;
        st_d = cnt_q == tail_n ? MVF_S_IDLE : MVF_S_TAIL;
      end
      default: st_d = MVF_S_IDLE;
    endcase
  end

  // plain characters straight to the line
  wire step = !emit || !tx_busy_q;
  assign tx_go = emit & ~tx_busy_q;
  assign tx_ch = ch;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= MVF_S_IDLE;
      cnt_q <= 4'h0;
      rec_q <= 2'h0;
      job_probe_q <= 1'b0;
    end else if (step) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rec_q <= rec_d;
      job_probe_q <= job_probe_d;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [31:0] stat_w = {16'h0000, rx_last_q, 4'h0, tx_busy_q, probe_pend_q, disp_pend_q, ~idle};
  wire [31:0] slot_rd = slot_reg == `MVF_SLOT_FMT ? fmt_q[slot_idx]
                      : slot_reg == `MVF_SLOT_INT ? int_q[slot_idx]
                      : slot_reg == `MVF_SLOT_FRC ? frc_q[slot_idx] : 32'h00000000;

  assign rdat_d = avs_address == `MVF_CTRL_OFS ? ctrl_q
                : avs_address == `MVF_BAUD_OFS ? {16'h0000, baud_q}
                : avs_address == `MVF_STAT_OFS ? stat_w
                : in_slots ? slot_rd : 32'h00000000;

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rdat_d;
    end
  end

endmodule

// ==== verif/mvf_framer_assertions.sv ====
// mvf_framer_assertions.sv: port checker for the framer
// assumes: bit time of at least 4 clocks, bound onto every framer instance
module mvf_framer_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic remote_switch_n,
  input wire logic edge_probe_n,
  input wire logic rxd,
  input wire logic txd
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  a_read_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait cycle");
  a_write_one_wait: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("write not answered after one wait cycle");
  a_wait_idle_low: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest high without request");
  a_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_rdata_reset: assert property (disable iff (1'b0) rst |=> avs_readdata == 32'h0)
    else $error("read data not cleared by reset");

  // ----------------------------------------
  // serial line
  // ----------------------------------------
  a_txd_reset_idle: assert property (disable iff (1'b0) rst |=> txd)
    else $error("serial output not idle after reset");
  a_space_width: assert property ($fell(txd) |-> !txd [*4])
    else $error("low bit shorter than bit time");
  a_mark_width: assert property ($rose(txd) |-> txd [*4])
    else $error("high bit shorter than bit time");

  c_switch: cover property ($fell(remote_switch_n));
  c_probe: cover property ($fell(edge_probe_n));
  c_read_done: cover property (avs_read && !avs_waitrequest);
endmodule

bind mvf_framer mvf_framer_assertions u_chk (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .remote_switch_n(remote_switch_n), .edge_probe_n(edge_probe_n), .rxd(rxd), .txd(txd)
);

// ==== verif/mvf_serial_peer.sv ====
// mvf_serial_peer.sv: terminal at the far end of the serial line
// assumes: bit time of BITC clocks, framing set by the bench
module mvf_serial_peer #(
  parameter int BITC = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic txd,
  input wire logic data8,
  input wire logic [1:0] parity,
  input wire logic stop2,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] q[$];
  int bad = 0;
  logic [7:0] c;
  logic p;

  initial rxd = 1'b1;

  // ----------------------------------------
  // receive side
  // ----------------------------------------
  // decode frame, check parity, stop, ascii
  initial forever begin
    @(posedge clk);
    if (!rst && !txd) begin
      repeat (BITC / 2) @(posedge clk);
      c = 8'h00;
      p = 1'b0;
      for (int i = 0; i < (data8 ? 8 : 7); i++) begin
        repeat (BITC) @(posedge clk);
        c[i] = txd;
        p = p ^ txd;
      end
      if (parity != 2'h0) begin
        repeat (BITC) @(posedge clk);
        if ((p ^ txd) != (parity == 2'h2)) bad++;
      end
      repeat (BITC) @(posedge clk);
      if (!txd || c[7]) bad++;
      q.push_back(c);
    end
  end

  // ----------------------------------------
  // send side
  // ----------------------------------------
  // frame one character towards the block
  task automatic send(input logic [7:0] ch);
    logic [7:0] d;
    d = data8 ? ch : {1'b0, ch[6:0]};
    @(posedge clk);
    rxd <= 1'b0;
    for (int i = 0; i < (data8 ? 8 : 7); i++) begin
      repeat (BITC) @(posedge clk);
      rxd <= d[i];
    end
    if (parity != 2'h0) begin
      repeat (BITC) @(posedge clk);
      rxd <= ^d ^ (parity == 2'h2);
    end
    repeat (BITC) @(posedge clk);
    rxd <= 1'b1;
    repeat (BITC * (stop2 ? 3 : 2)) @(posedge clk);
  endtask
endmodule

// ==== verif/mvf_framer_test.sv ====
// mvf_framer_test.sv: self-checking bench for the framer
// assumes: framer core, checker bind and serial peer compiled before
`include "mvf_defines.svh"
module mvf_framer_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic remote_switch_n = 1'b1;
  logic edge_probe_n = 1'b1;
  logic rxd;
  logic txd;
  logic data8 = 1'b1;
  logic [1:0] parity = 2'h0;
  logic stop2 = 1'b0;
  logic [31:0] r;
  int fail_count = 0;
  int n_compared = 0;
  string crlf = "\015\012";

  always #2 clk = ~clk;

  mvf_framer u_dut (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .remote_switch_n(remote_switch_n), .edge_probe_n(edge_probe_n), .rxd(rxd), .txd(txd)
  );

  mvf_serial_peer #(.BITC(4)) u_peer (
    .clk(clk), .rst(rst), .txd(txd), .data8(data8), .parity(parity), .stop2(stop2),
    .rxd(rxd)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      end_of_test();
    end
    @(posedge clk);
  endtask

  function automatic logic [31:0] fmt(input logic [7:0] l, input logic [1:0] k,
      input logic [1:0] s, input logic [2:0] f, input logic [3:0] ni, input logic [3:0] nf,
      input logic [3:0] ns);
    return {4'h0, ns, nf, ni, 1'b0, f, s, k, l};
  endfunction

  task automatic set_slot(input int i, input logic [31:0] f, input logic [31:0] iv,
                          input logic [31:0] fv);
    bus(1'b1, 8'(`MVF_SLOT_BASE + 16 * i), f, r);
    bus(1'b1, 8'(`MVF_SLOT_BASE + 16 * i + 4), iv, r);
    bus(1'b1, 8'(`MVF_SLOT_BASE + 16 * i + 8), fv, r);
  endtask

  task automatic pulse(input logic probe);
    if (probe)
      edge_probe_n <= 1'b0;
    else
      remote_switch_n <= 1'b0;
    repeat (8) @(posedge clk);
    edge_probe_n <= 1'b1;
    remote_switch_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic wait_char();
    int n;
    n = 0;
    while (u_peer.q.size() == 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      fail_count++;
      end_of_test();
    end
  endtask

  task automatic expect_text(input string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      wait_char();
      check({24'h0, u_peer.q.pop_front()}, {24'h0, s[i]});
    end
    check(32'(u_peer.bad), 32'h0);
    n = 0;
    do begin
      bus(1'b0, `MVF_STAT_OFS, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 100);
    check({31'h0, r[0]}, 32'h0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    bus(1'b0, `MVF_CTRL_OFS, 32'h0, r);
    check(r, `MVF_CTRL_RST);
    bus(1'b0, `MVF_BAUD_OFS, 32'h0, r);
    check(r, 32'(`MVF_BAUD_RST));
    bus(1'b0, 8'hFC, 32'h0, r);
    check(r, 32'h0);
    avs_byteenable <= 4'h1;
    bus(1'b1, `MVF_BAUD_OFS, 32'h0000FF04, r);
    avs_byteenable <= 4'hF;
    bus(1'b0, `MVF_BAUD_OFS, 32'h0, r);
    check(r, {16'h0000, `MVF_BAUD_RST & 16'hFF00} | 32'h4);
    bus(1'b1, `MVF_BAUD_OFS, 32'h4, r);
    bus(1'b0, `MVF_BAUD_OFS, 32'h0, r);
    check(r, 32'h4);
    set_slot(0, fmt(8'h58, 2'h0, 2'h0, 3'h0, 4'h2, 4'h2, 4'h0), 32'h41000000, 32'h290000);
    set_slot(1, fmt(8'h43, 2'h1, 2'h0, 3'h4, 4'h4, 4'h4, 4'h0), 32'h12600000, 32'h0);
    set_slot(2, fmt(8'h41, 2'h2, 2'h1, 3'h0, 4'h3, 4'h2, 4'h2), 32'h36000000, 32'h234500);
  endtask

  task automatic t_display();
    pulse(1'b0);
    expect_text({"X=+41.29 R", crlf, "C=+1260.0000 w", crlf,
                 "A=-360:23:45 W", crlf});
  endtask

  task automatic t_ctrlb();
    data8 <= 1'b0;
    parity <= 2'h1;
    stop2 <= 1'b1;
    bus(1'b1, `MVF_CTRL_OFS, 32'h0000024A, r);
    bus(1'b1, `MVF_SLOT_BASE, fmt(8'h58, 2'h0, 2'h0, 3'h7, 4'h2, 4'h2, 4'h0), r);
    u_peer.send(`MVF_CH_CTRLB);
    expect_text({"X=+41.29\"d", "\015\015\015"});
  endtask

  task automatic t_probe();
    data8 <= 1'b1;
    parity <= 2'h2;
    stop2 <= 1'b0;
    bus(1'b1, `MVF_CTRL_OFS, 32'h00000015, r);
    bus(1'b1, `MVF_SLOT_BASE, fmt(8'h58, 2'h0, 2'h2, 3'h0, 4'h2, 4'h2, 4'h0), r);
    pulse(1'b1);
    repeat (600) @(posedge clk);
    check(32'(u_peer.q.size()), 32'h0);
    bus(1'b1, `MVF_CTRL_OFS, 32'h00000215, r);
    pulse(1'b1);
    expect_text({"X  : 41.29 R", crlf});
  endtask

  task automatic t_circle();
    set_slot(1, fmt(8'h59, 2'h0, 2'h0, 3'h0, 4'h2, 4'h2, 4'h0), 32'h12000000, 32'h500000);
    set_slot(2, fmt(8'h5A, 2'h0, 2'h1, 3'h2, 4'h2, 4'h2, 4'h0), 32'h03000000, 32'h100000);
    bus(1'b1, `MVF_CTRL_OFS, 32'h00002235, r);
    pulse(1'b1);
    wait_char();
    pulse(1'b0);
    expect_text({"\103\103\130: 41.29 R", crlf, "\103\103\131:+12.50 R", crlf,
                 "\104\111\101:-03.10 D", crlf, crlf, "X=+41.29 R", crlf, crlf});
    bus(1'b1, `MVF_CTRL_OFS, 32'h00001215, r);
    pulse(1'b1);
    expect_text({"\103\114\130: 41.29 R", crlf, "\104\123\124:+12.50 R", crlf});
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_display();
    t_ctrlb();
    t_probe();
    t_circle();
    end_of_test();
  end
endmodule
